// *** rtl/ppfs_pkg.sv ***
// Purpose: Shared constants for the port fault supervisor.
// Assumes: 50 MHz system clock; register offsets are byte addresses.
// Notes: Long counts are also top-level parameters so tests can shorten them.
`default_nettype none
package ppfs_pkg;
    // Clock rate and the timing figures in their own units.
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned T_OVL_MS = 60;
    localparam int unsigned T_HLIM_US = 1700;
    localparam int unsigned T_SWF_US = 180;
    localparam int unsigned T_DIS_MS = 350;
    localparam int unsigned T_INR_MS = 50;
    localparam int unsigned ADC_SLOW_SPS = 14;
    localparam int unsigned ADC_FAST_SPS = 440;
    // Derived cycle counts.
    localparam int unsigned OVL_CYC = T_OVL_MS * (CLK_HZ / 1000);
    localparam int unsigned HLIM_UNIT_CYC = T_HLIM_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SWF_CYC = T_SWF_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DIS_CYC = T_DIS_MS * (CLK_HZ / 1000);
    localparam int unsigned INR_CYC = T_INR_MS * (CLK_HZ / 1000);
    localparam int unsigned ADC_SLOW_CYC = CLK_HZ / ADC_SLOW_SPS;
    localparam int unsigned ADC_FAST_CYC = CLK_HZ / ADC_FAST_SPS;
    // Overload timer counts up by this step and down by one.
    localparam int unsigned OVL_UP_STEP = 16;
    // Register offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HLTIME = 8'h04;
    localparam logic [7:0] REG_LIMIT = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_FAULT = 8'h10;
    localparam logic [7:0] REG_VOLT = 8'h14;
    localparam logic [7:0] REG_CURR = 8'h18;
    // Control register fields.
    localparam int CTRL_ON = 0;
    localparam int CTRL_OFF = 1;
    localparam int CTRL_DCEN = 2;
    localparam int CTRL_ACEN = 3;
    localparam int CTRL_FAST = 4;
    localparam int CTRL_PRST = 5;
    localparam int CTRL_HALF = 6;
    localparam logic [31:0] CTRL_RST = 32'h0000_0004;
    // Fault register fields.
    localparam int FLT_OVL = 0;
    localparam int FLT_HLIM = 1;
    localparam int FLT_DISC = 2;
    localparam int FLT_INR = 3;
    localparam int FLT_SWF = 4;
    localparam int FLT_W = 5;
    // Hard-limit codes for 425 mA at each sense resistance and for 850 mA at the half-ohm one.
    localparam logic [7:0] LIM_425_QTR = 8'h80;
    localparam logic [7:0] LIM_425_HALF = 8'h00;
    localparam logic [7:0] LIM_850_HALF = 8'h40;
    localparam int HLT_W = 4;
    localparam int ADC_ZERO_BITS = 5;
    localparam int RB_VALID = 16;
    typedef enum logic [1:0] {
        ST_OFF, ST_INRUSH, ST_ON, ST_SWFAIL
    } ppfs_state_e;
endpackage
`default_nettype wire

// *** rtl/ppfs_supervisor.sv ***
// Purpose: Digital fault supervision for one power-sourcing port.
// Assumes: Comparator inputs are synchronous to i_clk.
// Notes: Register reads return data in the cycle after the read strobe.
//
// Chosen here: strobed register access and the placing of the registers.
`default_nettype none
module ppfs_supervisor
    import ppfs_pkg::*;
#(
    parameter int unsigned P_OVL_CYC = OVL_CYC,
    parameter int unsigned P_HLIM_UNIT_CYC = HLIM_UNIT_CYC,
    parameter int unsigned P_SWF_CYC = SWF_CYC,
    parameter int unsigned P_DIS_CYC = DIS_CYC,
    parameter int unsigned P_INR_CYC = INR_CYC,
    parameter int unsigned P_ADC_SLOW_CYC = ADC_SLOW_CYC,
    parameter int unsigned P_ADC_FAST_CYC = ADC_FAST_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_over_cut,
    input wire logic i_over_lim,
    input wire logic i_under_min,
    input wire logic i_inrush_over,
    input wire logic i_out_not_up,
    input wire logic i_sw_abnormal,
    input wire logic i_adc_done,
    input wire logic [15:0] i_adc_volt,
    input wire logic [15:0] i_adc_curr,
    output logic o_port_en,
    output logic [7:0] o_limit_code,
    output logic o_gate_weak,
    output logic o_adc_fast,
    output logic o_adc_start
);
    localparam logic [25:0] OVL_LIM = 26'(P_OVL_CYC * OVL_UP_STEP);
    localparam logic [25:0] OVL_STEP = 26'(OVL_UP_STEP);
    localparam logic [20:0] HL_UNIT = 21'(P_HLIM_UNIT_CYC);
    localparam logic [15:0] SWF_LIM = 16'(P_SWF_CYC);
    localparam logic [25:0] DIS_LIM = 26'(P_DIS_CYC);
    localparam logic [25:0] INR_LIM = 26'(P_INR_CYC);
    localparam logic [21:0] ADC_SLOW = 22'(P_ADC_SLOW_CYC);
    localparam logic [21:0] ADC_FAST = 22'(P_ADC_FAST_CYC);

    ppfs_state_e state_reg, state_next;
    logic [31:0] ctrl_reg;
    logic [HLT_W-1:0] hltime_reg;
    logic [7:0] limit_reg;
    logic [FLT_W-1:0] fault_reg, fault_set;
    logic [25:0] ovl_reg, dis_reg, inr_reg;
    logic [20:0] hl_reg;
    logic [HLT_W-1:0] hl_mult_reg;
    logic [15:0] swf_reg;
    logic [21:0] adc_cnt_reg;
    logic [16:0] volt_reg, curr_reg;
    logic [7:0] lim_default;
    logic powered, dis_en, wr_ctrl, on_cmd, off_cmd, prst_cmd;
    logic ovl_exp, hl_exp, dis_exp, inr_exp, inr_fault, swf_exp;
    logic ovl_up;

    // The 425 mA code depends on which sense resistor is fitted.
    assign lim_default = ctrl_reg[CTRL_HALF] ? LIM_425_HALF : LIM_425_QTR;
    assign powered = (state_reg == ST_ON) || (state_reg == ST_INRUSH);
    // AC enable is accepted but simply selects DC detection.
    assign dis_en = ctrl_reg[CTRL_DCEN] | ctrl_reg[CTRL_ACEN];
    assign wr_ctrl = i_wr && (i_addr == REG_CTRL);
    assign on_cmd = wr_ctrl && i_wdata[CTRL_ON];
    assign off_cmd = wr_ctrl && i_wdata[CTRL_OFF];
    assign prst_cmd = wr_ctrl && i_wdata[CTRL_PRST];

    // Timer expiry events.
    assign ovl_up = i_over_cut || (hltime_reg == '0 && i_over_lim);
    assign ovl_exp = (state_reg == ST_ON) && ovl_up &&
                     (ovl_reg >= OVL_LIM - OVL_STEP);
    assign hl_exp = (state_reg == ST_ON) && (hltime_reg != '0) &&
                    i_over_lim && (hl_mult_reg == hltime_reg - 1'b1) &&
                    (hl_reg == HL_UNIT - 1'b1);
    assign dis_exp = (state_reg == ST_ON) && dis_en && i_under_min &&
                     (dis_reg == DIS_LIM - 1'b1);
    assign inr_exp = (state_reg == ST_INRUSH) && (inr_reg == INR_LIM - 1'b1);
    // An absent switch never brings the output up, so it lands here.
    assign inr_fault = inr_exp && (i_inrush_over || i_out_not_up);
    assign swf_exp = (state_reg != ST_SWFAIL) && i_sw_abnormal &&
                     (swf_reg == SWF_LIM - 1'b1);

    // Port state; a switch failure outranks every other event.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (on_cmd) begin
                    state_next = ST_INRUSH;
                end
            end
            ST_INRUSH: begin
                if (off_cmd || inr_fault) begin
                    state_next = ST_OFF;
                end else if (inr_exp) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (off_cmd || ovl_exp || hl_exp || dis_exp) begin
                    state_next = ST_OFF;
                end
            end
            default: begin
                if (prst_cmd) begin
                    state_next = ST_OFF; // Host port reset.
                end
            end
        endcase
        if (swf_exp) begin
            state_next = ST_SWFAIL;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Switch drive outputs follow the next state so they are registered.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_port_en <= 1'b0;
            o_gate_weak <= 1'b0;
        end else begin
            o_port_en <= (state_next == ST_ON) || (state_next == ST_INRUSH);
            o_gate_weak <= (state_next == ST_SWFAIL);
        end
    end

    // Control and timer-duration registers; command bits are self-clearing.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= CTRL_RST;
            hltime_reg <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= i_wdata & 32'h0000_005C;
            end
            if (i_wr && i_addr == REG_HLTIME) begin
                hltime_reg <= i_wdata[HLT_W-1:0];
            end
        end
    end

    // Programmed limit; hardware puts back 425 mA whenever power drops,
    // which wins over a host write in the same cycle.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            limit_reg <= LIM_425_QTR;
        end else if (powered && !(state_next == ST_ON ||
                                  state_next == ST_INRUSH)) begin
            limit_reg <= lim_default;
        end else if (i_wr && i_addr == REG_LIMIT) begin
            limit_reg <= i_wdata[7:0];
        end
    end

    // The comparator sees 425 mA during inrush and while off.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_limit_code <= LIM_425_QTR;
        end else if (state_next == ST_ON) begin
            o_limit_code <= limit_reg;
        end else begin
            o_limit_code <= lim_default;
        end
    end

    // Sticky faults: write one to clear, but a new event wins the cycle.
    always_comb begin
        fault_set = '0;
        fault_set[FLT_OVL] = ovl_exp && !swf_exp;
        fault_set[FLT_HLIM] = hl_exp && !swf_exp;
        fault_set[FLT_DISC] = dis_exp && !swf_exp;
        fault_set[FLT_INR] = inr_fault && !swf_exp;
        fault_set[FLT_SWF] = swf_exp;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fault_reg <= '0;
        end else if (i_wr && i_addr == REG_FAULT) begin
            fault_reg <= (fault_reg & ~i_wdata[FLT_W-1:0]) | fault_set;
        end else begin
            fault_reg <= fault_reg | fault_set;
        end
    end

    // Overload accumulator in sixteenths: up by 16, down by 1.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ovl_reg <= '0;
        end else if (state_next != ST_ON) begin
            ovl_reg <= '0;
        end else if (ovl_up) begin
            ovl_reg <= ovl_reg + OVL_STEP;
        end else if (ovl_reg != '0) begin
            ovl_reg <= ovl_reg - 1'b1;
        end
    end

    // Hard-limit timer: unit counter times a multiple of the field.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hl_reg <= '0;
            hl_mult_reg <= '0;
        end else if (state_next != ST_ON || hltime_reg == '0 ||
                     !i_over_lim) begin
            hl_reg <= '0;
            hl_mult_reg <= '0;
        end else if (hl_reg == HL_UNIT - 1'b1) begin
            hl_reg <= '0;
            hl_mult_reg <= hl_mult_reg + 1'b1;
        end else begin
            hl_reg <= hl_reg + 1'b1;
        end
    end

    // Disconnect timer restarts from zero whenever current returns.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dis_reg <= '0;
        end else if (state_next != ST_ON || !dis_en || !i_under_min) begin
            dis_reg <= '0;
        end else begin
            dis_reg <= dis_reg + 1'b1;
        end
    end

    // Inrush timer runs for the whole inrush period. It starts one edge
    // after entry, so the port spends exactly P_INR_CYC cycles in inrush.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            inr_reg <= '0;
        end else if (state_reg != ST_INRUSH || state_next != ST_INRUSH) begin
            inr_reg <= '0;
        end else begin
            inr_reg <= inr_reg + 1'b1;
        end
    end

    // Switch abnormality must persist without a break to count.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            swf_reg <= '0;
        end else if (!i_sw_abnormal || state_next == ST_SWFAIL) begin
            swf_reg <= '0;
        end else begin
            swf_reg <= swf_reg + 1'b1;
        end
    end

    // Sample pacing; the analog side converts on each start pulse.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            adc_cnt_reg <= '0;
            o_adc_start <= 1'b0;
            o_adc_fast <= 1'b0;
        end else begin
            o_adc_fast <= ctrl_reg[CTRL_FAST];
            if (adc_cnt_reg >= (ctrl_reg[CTRL_FAST] ? ADC_FAST : ADC_SLOW)
                - 1'b1) begin
                adc_cnt_reg <= '0;
                o_adc_start <= 1'b1;
            end else begin
                adc_cnt_reg <= adc_cnt_reg + 1'b1;
                o_adc_start <= 1'b0;
            end
        end
    end

    // Results carry a valid bit that only lives while power is on.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            volt_reg <= '0;
            curr_reg <= '0;
        end else if (!powered) begin
            volt_reg[RB_VALID] <= 1'b0;
            curr_reg[RB_VALID] <= 1'b0;
        end else if (i_adc_done) begin
            volt_reg <= {1'b1, i_adc_volt};
            curr_reg <= {1'b1, i_adc_curr};
            if (ctrl_reg[CTRL_FAST]) begin
                volt_reg[ADC_ZERO_BITS-1:0] <= '0;
                curr_reg[ADC_ZERO_BITS-1:0] <= '0;
            end
        end
    end

    // Read data appear one cycle after the strobe; unmapped reads zero.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            if (i_addr == REG_CTRL) begin
                o_rdata <= ctrl_reg;
            end else if (i_addr == REG_HLTIME) begin
                o_rdata <= {28'h0, hltime_reg};
            end else if (i_addr == REG_LIMIT) begin
                o_rdata <= {24'h0, limit_reg};
            end else if (i_addr == REG_STATUS) begin
                o_rdata <= {28'h0, o_gate_weak, o_port_en, state_reg};
            end else if (i_addr == REG_FAULT) begin
                o_rdata <= {27'h0, fault_reg};
            end else if (i_addr == REG_VOLT) begin
                o_rdata <= {15'h0, volt_reg};
            end else if (i_addr == REG_CURR) begin
                o_rdata <= {15'h0, curr_reg};
            end else begin
                o_rdata <= '0;
            end
        end else begin
            o_rdata <= '0;
        end
    end

    // Checks on the supervisor's own registers and outputs.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_ovl_up;
        (state_reg == ST_ON) && i_over_cut && !ovl_exp && !off_cmd &&
        !hl_exp && !dis_exp && !swf_exp
        |=> (ovl_reg == $past(ovl_reg) + OVL_STEP) && o_port_en;
    endproperty
    a_ovl_up: assert property (p_ovl_up)
        else $error("Overload timer did not count up by sixteen.");

    property p_ovl_down;
        (state_reg == ST_ON) && !i_over_cut && !i_over_lim &&
        (ovl_reg != '0) && (state_next == ST_ON)
        |=> ovl_reg == $past(ovl_reg) - 1'b1;
    endproperty
    a_ovl_down: assert property (p_ovl_down)
        else $error("Overload timer did not count down by one.");

    property p_ovl_trip;
        ovl_exp |=> !o_port_en && fault_reg[FLT_OVL] && ovl_reg == '0;
    endproperty
    a_ovl_trip: assert property (p_ovl_trip)
        else $error("Overload expiry did not turn the port off.");

    property p_hl_idle;
        hltime_reg == '0 |=> hl_reg == '0 && !fault_set[FLT_HLIM];
    endproperty
    a_hl_idle: assert property (p_hl_idle)
        else $error("Hard-limit timer ran with a zero field.");

    property p_hl_trip;
        hl_exp && !swf_exp |=> !o_port_en && fault_reg[FLT_HLIM];
    endproperty
    a_hl_trip: assert property (p_hl_trip)
        else $error("Hard-limit expiry did not turn the port off.");

    property p_hl_share;
        (state_reg == ST_ON) && (hltime_reg == '0) && i_over_lim &&
        (state_next == ST_ON) |=> ovl_reg == $past(ovl_reg) + OVL_STEP;
    endproperty
    a_hl_share: assert property (p_hl_share)
        else $error("Hard-limit event did not count on overload timer.");

    property p_inrush_lim;
        state_reg == ST_INRUSH |-> o_limit_code == lim_default;
    endproperty
    a_inrush_lim: assert property (p_inrush_lim)
        else $error("Limit code was not 425 mA during inrush.");

    property p_off_restore;
        $fell(o_port_en) |-> limit_reg == $past(lim_default);
    endproperty
    a_off_restore: assert property (p_off_restore)
        else $error("Limit setting not restored at turn-off.");

    property p_swf;
        swf_exp |=> o_gate_weak && !o_port_en && fault_reg[FLT_SWF];
    endproperty
    a_swf: assert property (p_swf)
        else $error("Switch failure did not disable the port.");

    property p_valid;
        !powered |=> !volt_reg[RB_VALID] && !curr_reg[RB_VALID];
    endproperty
    a_valid: assert property (p_valid)
        else $error("Readback stayed valid with power off.");

    property p_nodis;
        !dis_en |=> dis_reg == '0 && !fault_reg[FLT_DISC] ||
                    $past(fault_reg[FLT_DISC]);
    endproperty
    a_nodis: assert property (p_nodis)
        else $error("Disconnect acted while disabled.");

    c_ovl: cover property (ovl_exp);
    c_hl: cover property (hl_exp);
    c_dis: cover property (dis_exp);
    c_swf: cover property (swf_exp);
endmodule
`default_nettype wire

// *** verification/ppfs_adc_model.sv ***
// Purpose: Readback converter stand-in for the port supervisor bench.
// Assumes: Start pulses from the design are one cycle wide.
// Notes: Result lines toggle between results, so stale data never looks held.
`default_nettype none
module ppfs_adc_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    output logic o_done,
    output logic [15:0] o_volt,
    output logic [15:0] o_curr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] dly_reg;
    // Answer each start three cycles later with a fixed result.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            dly_reg <= 2'h0;
            o_done <= 1'b0;
            o_volt <= 16'h0000;
            o_curr <= 16'h0000;
        end else begin
            dly_reg <= {dly_reg[0], i_start};
            o_done <= dly_reg[1];
            if (dly_reg[1]) begin
                o_volt <= 16'h1234;
                o_curr <= 16'h0FFF;
            end else begin
                o_volt <= ~o_volt;
                o_curr <= ~o_curr;
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the port fault supervisor.
// Assumes: Shortened timer parameters; comparators driven by the bench.
// Notes: Expected counts follow from the parameters set at the instance.
`default_nettype none
module tb_top;
    import ppfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_rst;
    logic i_wr;
    logic i_rd;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic [5:0] cmp;
    logic [31:0] o_rdata, d;
    logic [7:0] o_limit_code;
    logic o_port_en, o_gate_weak, o_adc_fast, o_adc_start, done;
    logic [15:0] volt, curr;
    int num_errors = 0;
    int check_count = 0;
    int cnt;
    // Free-running 50 MHz clock.
    always #10 i_clk = ~i_clk;
    ppfs_supervisor #(.P_OVL_CYC(20), .P_HLIM_UNIT_CYC(5), .P_SWF_CYC(10),
        .P_DIS_CYC(30), .P_INR_CYC(15), .P_ADC_SLOW_CYC(40),
        .P_ADC_FAST_CYC(8)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_over_cut(cmp[0]), .i_over_lim(cmp[1]),
        .i_under_min(cmp[2]), .i_inrush_over(cmp[3]),
        .i_out_not_up(cmp[4]), .i_sw_abnormal(cmp[5]), .i_adc_done(done),
        .i_adc_volt(volt), .i_adc_curr(curr), .o_port_en(o_port_en),
        .o_limit_code(o_limit_code), .o_gate_weak(o_gate_weak),
        .o_adc_fast(o_adc_fast), .o_adc_start(o_adc_start));
    ppfs_adc_model u_adc (.i_clk(i_clk), .i_rst(i_rst),
        .i_start(o_adc_start), .o_done(done), .o_volt(volt), .o_curr(curr));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Holds one comparator high for exactly n sampling edges.
    task automatic hold(input int b, input int n);
        @(posedge i_clk);
        cmp[b] <= 1'b1;
        repeat (n) @(posedge i_clk);
        cmp[b] <= 1'b0;
        idle(2);
    endtask
    task automatic flt(input logic [31:0] e);
        rd(REG_FAULT);
        chk(d, e);
        wr(REG_FAULT, 32'h1F);
    endtask
    task automatic pon(input logic [31:0] c);
        wr(REG_LIMIT, 32'hC0);
        wr(REG_CTRL, c);
        idle(2);
        chk(32'(o_limit_code), 32'h80);
        idle(16);
    endtask
    task automatic on_is(input logic e);
        chk(32'(o_port_en), 32'(e));
    endtask
    task automatic per();
        cnt = 0;
        repeat (2) begin
            while (o_adc_start !== 1'b1 && cnt < 200) begin
                idle(1);
                cnt++;
            end
            idle(1);
        end
        cnt = 1;
        while (o_adc_start !== 1'b1 && cnt < 200) begin
            idle(1);
            cnt++;
        end
    endtask
    task automatic t_ovl();
        pon(32'h05);
        chk(32'(o_limit_code), 32'hC0);
        hold(0, 19);
        on_is(1'b1);
        chk(32'(o_limit_code), 32'hC0);
        idle(30);
        hold(0, 2);
        on_is(1'b1);
        hold(0, 2);
        on_is(1'b0);
        chk(32'(o_limit_code), 32'h80);
        idle(3);
        flt(32'h01);
        $display("overload test done");
    endtask
    task automatic t_hlim();
        wr(REG_HLTIME, 32'h2);
        pon(32'h05);
        hold(1, 9);
        on_is(1'b1);
        hold(1, 10);
        on_is(1'b0);
        flt(32'h02);
        wr(REG_HLTIME, 32'h0);
        pon(32'h05);
        hold(1, 20);
        on_is(1'b0);
        flt(32'h01);
        $display("hard limit test done");
    endtask
    task automatic t_swf();
        pon(32'h05);
        hold(5, 9);
        on_is(1'b1);
        hold(5, 10);
        chk(32'({o_port_en, o_gate_weak}), 32'h1);
        rd(REG_STATUS);
        chk(d, 32'h0B);
        flt(32'h10);
        wr(REG_CTRL, 32'h24);
        rd(REG_STATUS);
        chk(d, 32'h0);
        for (int b = 3; b < 5; b++) begin
            @(posedge i_clk);
            cmp[b] <= 1'b1;
            pon(32'h05);
            on_is(1'b0);
            flt(32'h08);
            cmp[b] <= 1'b0;
        end
        $display("switch test done");
    endtask
    task automatic t_disc();
        pon(32'h05);
        hold(2, 29);
        hold(2, 29);
        on_is(1'b1);
        hold(2, 30);
        on_is(1'b0);
        flt(32'h04);
        pon(32'h01);
        hold(2, 40);
        on_is(1'b1);
        wr(REG_CTRL, 32'h02);
        pon(32'h09);
        hold(2, 30);
        on_is(1'b0);
        flt(32'h04);
        $display("disconnect test done");
    endtask
    task automatic t_adc();
        pon(32'h15);
        chk(32'(o_adc_fast), 32'h1);
        per();
        chk(32'(cnt), 32'd8);
        rd(REG_VOLT);
        chk(d, 32'h0001_1220);
        rd(REG_CURR);
        chk(d, 32'h0001_0FE0);
        wr(REG_CTRL, 32'h06);
        idle(2);
        rd(REG_VOLT);
        chk(32'(d[16]), 32'h0);
        per();
        chk(32'(cnt), 32'd40);
        rd(8'h20);
        chk(d, 32'h0);
        // Half-ohm sense selects the other 425 mA code while off.
        wr(REG_CTRL, 32'h44);
        idle(2);
        chk(32'(o_limit_code), 32'h00);
        $display("readback test done");
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence after a ten-cycle reset.
    initial begin
        i_rst <= 1'b1;
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        i_addr <= 8'h00;
        i_wdata <= 32'h0;
        cmp <= 6'h00;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(REG_CTRL);
        chk(d, 32'h04);
        t_ovl();
        t_hlim();
        t_swf();
        t_disc();
        t_adc();
        give_verdict();
    end
    // Watchdog well beyond the several hundred cycles the tests need.
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
